/* ssru_pkg.sv */
/*
 * Shared constants and types of the status and service request unit.
 * Assumes a command decoder upstream that turns host messages into the
 * opcodes below, and a nonvolatile image of the power-on settings.
 */
package ssru_pkg;

    localparam int SSRU_SLOTS      = 8;
    localparam int SSRU_SLOT_IDX_W = 3;

    localparam logic [7:0] SSRU_SRE_RST = 8'h00;
    localparam logic [7:0] SSRU_ESE_RST = 8'h00;
    localparam logic       SSRU_PSC_RST = 1'b1;

    localparam int SSRU_STB_OPER = 7;
    localparam int SSRU_STB_MSS  = 6;
    localparam int SSRU_STB_ESB  = 5;
    localparam int SSRU_STB_MAV  = 4;
    localparam int SSRU_STB_QUES = 3;

    localparam logic [7:0] SSRU_EVT_QUES = 8'h00;
    localparam logic [7:0] SSRU_EVT_ESR  = 8'h01;
    localparam logic [7:0] SSRU_EVT_OPER = 8'h02;

    typedef enum logic [3:0] {
        OP_SEQ, OP_SAV, OP_RCL, OP_SRE_WR, OP_SRE_RD, OP_ESE_WR,
        OP_ESE_RD, OP_STB_RD, OP_TRG, OP_WAI, OP_RST, OP_CLS,
        OP_PSC_WR, OP_PSC_RD, OP_EVT_RD, OP_OVL
    } ssru_op_e;

    typedef struct packed {
        ssru_op_e   op;
        logic [7:0] arg;
    } ssru_cmd_s;

    typedef struct packed {
        logic       psc;
        logic [7:0] service_request_mask;
        logic [7:0] ese;
    } ssru_nv_s;

endpackage

/* ssru_slot_store.sv */
/*
 * Saved-state store: a set of slots written by index and read back by
 * index with a registered answer one cycle later.
 * Assumes the slot contents live in retained storage, so they are not
 * cleared by reset; only the read answer is.
 */
`timescale 1ns/100ps
module ssru_slot_store #(
    parameter int SLOTS = 8,
    parameter int IDX_W = 3,
    parameter int DW    = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wr_en_in,
    input  wire logic [IDX_W-1:0] wr_idx_in,
    input  wire logic [DW-1:0]    wr_data_in,
    input  wire logic             rd_en_in,
    input  wire logic [IDX_W-1:0] rd_idx_in,
    output logic                  rd_valid_out,
    output logic      [DW-1:0]    rd_data_out
);
    logic [DW-1:0] slot_reg [SLOTS];

    for (genvar i = 0; i < SLOTS; i++) begin : g_slot
        always_ff @(posedge clk_in) begin
            if (wr_en_in && wr_idx_in == IDX_W'(i)) begin
                slot_reg[i] <= wr_data_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out  <= '0;
        end else begin
            rd_valid_out <= rd_en_in;
            rd_data_out  <= rd_en_in ? slot_reg[rd_idx_in] : rd_data_out;
        end
    end

    chk_slot_readback: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (wr_en_in && !rd_en_in) ##1 !wr_en_in ##1
        (rd_en_in && !wr_en_in && rd_idx_in == $past(wr_idx_in, 2))
        |=> rd_data_out == $past(wr_data_in, 3))
        else $error("saved slot does not read back");
endmodule

/* ssru_top.sv */
/*
 * Status byte, service request and common command logic of a programmable
 * source: masks, status summary, serial poll, bus trigger, save/recall,
 * and the wait-for-overlapped-commands hold-off.
 * Assumes decoded commands with a valid/ready handshake, summary pulses
 * from the lower event groups, and a nonvolatile image of the masks.
 */
// Notes on behaviour
// - Save stores the present state word in one of eight retained slots.
// - Eight-bit enable mask; bit 6 is OR of enabled status byte bits.
// - Serial poll clears request-for-service but not the master summary.
// - A zero enable mask never raises a service request.
// - Power-on does reset, status clear, and zeroes both enable masks when the power-on clear setting is 1.
// - Status byte query returns the byte and changes no bit.
// - Event-fed summary bits clear only when their event register is read or status is cleared.
// - Serial poll bit 6 is request-for-service; query bit 6 is summary.
// - Layout: 7 oper, 6 summary, 5 event, 4 message, 3 quest, 2-0 zero.
// - Bus trigger reaches every subsystem whose trigger source is bus.
// - Wait holds off commands until all earlier ones have finished or a command arrives.
// - Only the overlapped command (OP_OVL) runs overlapped; trigger and all others in order.
// - Any command arriving during a wait cancels the wait.
// - Power-on clear setting 1 zeroes masks; 0 restores them from storage.
// - Reset or device clear clears status but keeps the enable masks.
`timescale 1ns/100ps
module ssru_top #(
    parameter int N_SUB  = 4,
    parameter int STW    = 32,
    parameter int PEND_W = 4
) (
    input  wire logic                CLK_SYS_IN,
    input  wire logic                RST_N_IN,
    input  wire logic                CMD_VALID_IN,
    input  wire ssru_pkg::ssru_cmd_s CMD_IN,
    output logic                     CMD_READY_OUT,
    output logic                     RSP_VALID_OUT,
    output logic [7:0]               RSP_DATA_OUT,
    input  wire logic                SPOLL_IN,
    output logic                     SPOLL_VALID_OUT,
    output logic [7:0]               SPOLL_DATA_OUT,
    output logic                     SRQ_OUT,
    input  wire logic                DCL_IN,
    input  wire logic                GET_IN,
    input  wire logic                OPER_SUM_IN,
    input  wire logic                QUES_SUM_IN,
    input  wire logic                ESB_SUM_IN,
    input  wire logic                MAV_IN,
    output logic                     STATUS_CLR_OUT,
    output logic                     DEV_RST_OUT,
    output logic [7:0]               ESE_MASK_OUT,
    input  wire logic [N_SUB-1:0]    TRIG_SRC_BUS_IN,
    output logic [N_SUB-1:0]         TRIG_OUT,
    output logic                     OVL_START_OUT,
    input  wire logic                OVL_DONE_IN,
    output logic                     SEQ_START_OUT,
    input  wire logic [STW-1:0]      STATE_IN,
    output logic                     RCL_VALID_OUT,
    output logic [STW-1:0]           RCL_DATA_OUT,
    input  wire ssru_pkg::ssru_nv_s  NV_IN,
    output logic                     NV_WR_OUT,
    output ssru_pkg::ssru_nv_s       NV_DATA_OUT
);
    import ssru_pkg::*;

    typedef enum logic [1:0] {ST_PON, ST_IDLE, ST_WAIT} ssru_state_e;

    ssru_state_e       state_reg, state_next;
    logic              ready_next;
    logic [7:0]        sre_reg, sre_next, ese_next;
    logic              psc_reg, psc_next;
    logic              oper_reg, oper_next, ques_reg, ques_next;
    logic              esb_reg, esb_next;
    logic              rqs_next, mss_prev_reg;
    logic [PEND_W-1:0] pend_reg, pend_next;
    logic [7:0]        stb_core, rsp_data_next;
    logic              rsp_valid_next, nv_wr_next;
    logic [N_SUB-1:0]  trig_next;

    wire ssru_op_e   op       = CMD_IN.op;
    wire logic [7:0] arg      = CMD_IN.arg;
    wire logic       take     = CMD_VALID_IN && CMD_READY_OUT;
    wire logic       pon      = state_reg == ST_PON;
    wire logic       is_op_rd = op == OP_SRE_RD || op == OP_ESE_RD
                                || op == OP_PSC_RD || op == OP_STB_RD;
    wire logic       rd_evt   = take && op == OP_EVT_RD;
    wire logic       rd_oper  = rd_evt && arg == SSRU_EVT_OPER;
    wire logic       rd_ques  = rd_evt && arg == SSRU_EVT_QUES;
    wire logic       rd_esr   = rd_evt && arg == SSRU_EVT_ESR;
    wire logic       dev_rst  = pon || DCL_IN || (take && op == OP_RST);
    wire logic       clr_all  = dev_rst || (take && op == OP_CLS);
    wire logic       trg_cmd  = (take && op == OP_TRG) || GET_IN;
    wire logic       ovl_cmd  = take && op == OP_OVL;
    wire logic       ovl_dec  = OVL_DONE_IN && pend_reg != '0;
    // master summary from masked status bits
    wire logic       mss      = |(stb_core & sre_reg);
    wire logic       rqs_set  = mss && !mss_prev_reg && !SRQ_OUT;

    always_comb begin
        stb_core                = 8'h00;
        stb_core[SSRU_STB_OPER] = oper_reg;
        stb_core[SSRU_STB_ESB]  = esb_reg;
        stb_core[SSRU_STB_MAV]  = MAV_IN;
        stb_core[SSRU_STB_QUES] = ques_reg;
    end

    // summary bits clear only on their event read or a status clear
    assign oper_next = OPER_SUM_IN || (oper_reg && !(clr_all || rd_oper));
    assign ques_next = QUES_SUM_IN || (ques_reg && !(clr_all || rd_ques));
    assign esb_next  = ESB_SUM_IN || (esb_reg && !(clr_all || rd_esr));

    // poll clears request; zero mask blocks it
    assign rqs_next = (rqs_set || (SRQ_OUT && !(SPOLL_IN || clr_all)))
                      && sre_reg != 8'h00;

    // power-on loads masks; restore only when not cleared
    assign sre_next = pon ? (NV_IN.psc ? SSRU_SRE_RST : NV_IN.service_request_mask)
                    : (take && op == OP_SRE_WR) ? arg : sre_reg;
    assign ese_next = pon ? (NV_IN.psc ? SSRU_ESE_RST : NV_IN.ese)
                    : (take && op == OP_ESE_WR) ? arg : ESE_MASK_OUT;
    assign psc_next = pon ? NV_IN.psc
                    : (take && op == OP_PSC_WR) ? arg != 8'h00 : psc_reg;
    // masks kept in storage while clearing is off
    assign nv_wr_next = take && (op == OP_PSC_WR
                        || ((op == OP_SRE_WR || op == OP_ESE_WR)
                            && !psc_reg));

    // query returns the byte without touching it
    assign rsp_valid_next = take && is_op_rd;
    assign rsp_data_next  = op == OP_SRE_RD ? sre_reg
                          : op == OP_ESE_RD ? ESE_MASK_OUT
                          : op == OP_PSC_RD ? {7'h00, psc_reg}
                          : stb_core | {1'b0, mss, 6'h00};

    assign pend_next = pend_reg + PEND_W'(ovl_cmd) - PEND_W'(ovl_dec);

    // wait hold-off; arrival cancels the wait
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_PON: state_next = ST_IDLE;
            ST_IDLE: begin
                if (take && op == OP_WAI) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (CMD_VALID_IN || pend_reg == '0) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end
    assign ready_next = state_next == ST_IDLE;

    for (genvar i = 0; i < N_SUB; i++) begin : g_trig
        assign trig_next[i] = trg_cmd && TRIG_SRC_BUS_IN[i];
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            state_reg     <= ST_PON;
            CMD_READY_OUT <= 1'b0;
            pend_reg      <= '0;
            SEQ_START_OUT <= 1'b0;
            OVL_START_OUT <= 1'b0;
            TRIG_OUT      <= '0;
        end else begin
            state_reg     <= state_next;
            CMD_READY_OUT <= ready_next;
            pend_reg      <= pend_next;
            SEQ_START_OUT <= take && op == OP_SEQ;
            OVL_START_OUT <= ovl_cmd;
            TRIG_OUT      <= trig_next;
        end
    end

    // clears other than power-on touch status, never the masks
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            oper_reg       <= 1'b0;
            ques_reg       <= 1'b0;
            esb_reg        <= 1'b0;
            SRQ_OUT        <= 1'b0;
            mss_prev_reg   <= 1'b0;
            STATUS_CLR_OUT <= 1'b0;
            DEV_RST_OUT    <= 1'b0;
        end else begin
            oper_reg       <= oper_next;
            ques_reg       <= ques_next;
            esb_reg        <= esb_next;
            SRQ_OUT        <= rqs_next;
            mss_prev_reg   <= mss;
            STATUS_CLR_OUT <= clr_all;
            DEV_RST_OUT    <= dev_rst;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            sre_reg      <= SSRU_SRE_RST;
            ESE_MASK_OUT <= SSRU_ESE_RST;
            psc_reg      <= SSRU_PSC_RST;
            NV_WR_OUT    <= 1'b0;
            NV_DATA_OUT  <= '0;
        end else begin
            sre_reg      <= sre_next;
            ESE_MASK_OUT <= ese_next;
            psc_reg      <= psc_next;
            NV_WR_OUT    <= nv_wr_next;
            NV_DATA_OUT  <= '{psc: psc_next, service_request_mask: sre_next, ese: ese_next};
        end
    end

    // poll answer carries the request bit
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            RSP_VALID_OUT   <= 1'b0;
            RSP_DATA_OUT    <= 8'h00;
            SPOLL_VALID_OUT <= 1'b0;
            SPOLL_DATA_OUT  <= 8'h00;
        end else begin
            RSP_VALID_OUT   <= rsp_valid_next;
            RSP_DATA_OUT    <= rsp_valid_next ? rsp_data_next : RSP_DATA_OUT;
            SPOLL_VALID_OUT <= SPOLL_IN;
            SPOLL_DATA_OUT  <= SPOLL_IN ? (stb_core | {1'b0, SRQ_OUT, 6'h00})
                                        : SPOLL_DATA_OUT;
        end
    end

    ssru_slot_store #(
        .SLOTS (SSRU_SLOTS),
        .IDX_W (SSRU_SLOT_IDX_W),
        .DW    (STW)
    ) u_store (
        .clk_in       (CLK_SYS_IN),
        .rst_n_in     (RST_N_IN),
        .wr_en_in     (take && op == OP_SAV),
        .wr_idx_in    (arg[SSRU_SLOT_IDX_W-1:0]),
        .wr_data_in   (STATE_IN),
        .rd_en_in     (take && op == OP_RCL),
        .rd_idx_in    (arg[SSRU_SLOT_IDX_W-1:0]),
        .rd_valid_out (RCL_VALID_OUT),
        .rd_data_out  (RCL_DATA_OUT)
    );

    chk_mss_in_query: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        take && op == OP_STB_RD |=> RSP_VALID_OUT
        && RSP_DATA_OUT[SSRU_STB_MSS] == |($past(stb_core) & $past(sre_reg)))
        else $error("query bit 6 is not the masked summary");

    chk_poll_clears_rqs: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        SPOLL_IN && !rqs_set |=> !SRQ_OUT)
        else $error("serial poll left the request set");

    chk_zero_mask_quiet: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        sre_reg == 8'h00 |=> !SRQ_OUT)
        else $error("request raised with a zero mask");

    chk_pon_mask_clear: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        pon && NV_IN.psc |=> sre_reg == 8'h00 && ESE_MASK_OUT == 8'h00
        && STATUS_CLR_OUT && DEV_RST_OUT)
        else $error("power-on did not clear masks and status");

    chk_pon_mask_keep: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        pon && !NV_IN.psc |=> sre_reg == $past(NV_IN.service_request_mask))
        else $error("power-on did not restore the mask");

    chk_query_no_clear: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        take && op == OP_STB_RD && oper_reg && !DCL_IN |=> oper_reg)
        else $error("status query changed the byte");

    chk_summary_holds: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        ques_reg && !rd_ques && !clr_all |=> ques_reg)
        else $error("summary bit cleared without event read");

    chk_poll_bit6: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        SPOLL_IN |=> SPOLL_VALID_OUT
        && SPOLL_DATA_OUT[SSRU_STB_MSS] == $past(SRQ_OUT))
        else $error("poll bit 6 is not the request bit");

    chk_stb_layout: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        take && op == OP_STB_RD |=> RSP_DATA_OUT[2:0] == 3'h0
        && RSP_DATA_OUT[SSRU_STB_MAV] == $past(MAV_IN)
        && RSP_DATA_OUT[SSRU_STB_OPER] == $past(oper_reg))
        else $error("status byte layout wrong");

    chk_bus_trigger: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        GET_IN |=> TRIG_OUT == $past(TRIG_SRC_BUS_IN))
        else $error("bus trigger not delivered");

    chk_wait_holds: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state_reg == ST_WAIT && pend_reg != '0 && !CMD_VALID_IN
        |=> !CMD_READY_OUT)
        else $error("wait released with work pending");

    chk_wait_cancel: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state_reg == ST_WAIT && CMD_VALID_IN |=> CMD_READY_OUT)
        else $error("arriving command did not cancel wait");

    chk_overlap_start: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        ovl_cmd && !ovl_dec |=> OVL_START_OUT && pend_reg != '0)
        else $error("overlapped command not tracked");

    chk_reset_keeps_mask: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        take && op == OP_RST |=> sre_reg == $past(sre_reg)
        && ESE_MASK_OUT == $past(ESE_MASK_OUT) && STATUS_CLR_OUT)
        else $error("reset changed an enable mask");

    chk_rqs_on_rise: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        rqs_set |=> SRQ_OUT)
        else $error("rising summary did not raise request");
endmodule

/* ssru_host_model.sv */
/*
 * Bus controller model: hands decoded commands to the unit and polls it.
 * Assumes each task is entered just after a falling clock edge.
 */
`timescale 1ns/100ps
module ssru_host_model (
    input  wire logic           clk_in,
    input  wire logic           cmd_ready_in,
    output logic                cmd_valid_out,
    output ssru_pkg::ssru_cmd_s cmd_out,
    output logic                spoll_out
);
    import ssru_pkg::*;

    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '{op: OP_SEQ, arg: 8'h00};
        spoll_out = 1'b0;
    end

    // Returns at the falling edge where a one-cycle answer stands.
    // host cancels a wait by sending.
    task automatic send(input ssru_op_e op, input logic [7:0] arg,
                        output bit ok);
        ok = 1'b0;
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_out = '{op: op, arg: arg};
        for (int n = 0; n < 64 && !ok; n++) begin
            if (cmd_ready_in === 1'b1) ok = 1'b1;
            @(negedge clk_in);
        end
        cmd_valid_out = 1'b0;
        cmd_out = ssru_cmd_s'(~cmd_out);
    endtask

    task automatic poll();
        @(negedge clk_in);
        spoll_out = 1'b1;
        @(negedge clk_in);
        spoll_out = 1'b0;
    endtask
endmodule

/* ssru_top_tb.sv */
/*
 * Self-checking bench of the status and service request unit.
 * Assumes the host model drives commands; the bench plays the status
 * groups, the trigger sources and the overlapped-command executor.
 */
`timescale 1ns/100ps
module ssru_top_tb;
    import ssru_pkg::*;

    localparam int ovl_lat = 8;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid, cmd_ready, rsp_valid, spoll, spoll_valid, srq;
    logic        st_clr, dev_rst, ovl_start, seq_start, rcl_valid, nv_wr;
    logic        dcl = 1'b0, get = 1'b0, mav = 1'b0, ovl_done = 1'b0;
    logic        oper = 1'b0, ques = 1'b0, esb = 1'b0;
    logic [7:0]  rsp_data, spoll_data, ese_mask;
    logic [3:0]  trig_src = 4'h0, trig;
    logic [31:0] state = 32'h0, rcl_data;
    ssru_cmd_s   cmd;
    ssru_nv_s    nv = '{psc: 1'b1, service_request_mask: 8'h00, ese: 8'h00};
    ssru_nv_s    nv_data;
    int          errors = 0;
    int          n_checks = 0;
    int          n;
    bit          ok, ovl_busy;

    always #10 clk = ~clk;

    ssru_top ssru_top_inst (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(cmd_valid),
        .CMD_IN(cmd), .CMD_READY_OUT(cmd_ready), .RSP_VALID_OUT(rsp_valid),
        .RSP_DATA_OUT(rsp_data), .SPOLL_IN(spoll),
        .SPOLL_VALID_OUT(spoll_valid), .SPOLL_DATA_OUT(spoll_data),
        .SRQ_OUT(srq), .DCL_IN(dcl), .GET_IN(get), .OPER_SUM_IN(oper),
        .QUES_SUM_IN(ques), .ESB_SUM_IN(esb), .MAV_IN(mav),
        .STATUS_CLR_OUT(st_clr), .DEV_RST_OUT(dev_rst),
        .ESE_MASK_OUT(ese_mask), .TRIG_SRC_BUS_IN(trig_src),
        .TRIG_OUT(trig), .OVL_START_OUT(ovl_start), .OVL_DONE_IN(ovl_done),
        .SEQ_START_OUT(seq_start), .STATE_IN(state),
        .RCL_VALID_OUT(rcl_valid), .RCL_DATA_OUT(rcl_data), .NV_IN(nv),
        .NV_WR_OUT(nv_wr), .NV_DATA_OUT(nv_data));

    ssru_host_model ssru_host_model_inst (
        .clk_in(clk), .cmd_ready_in(cmd_ready), .cmd_valid_out(cmd_valid),
        .cmd_out(cmd), .spoll_out(spoll));

    // Executor of overlapped commands, one at a time, fixed latency.
    initial forever begin
        @(negedge clk);
        if (ovl_start === 1'b1) begin
            ovl_busy = 1'b1;
            repeat (ovl_lat) @(negedge clk);
            ovl_done = 1'b1;
            @(negedge clk);
            ovl_done = 1'b0;
            ovl_busy = 1'b0;
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic do_cmd(input ssru_op_e op, input logic [7:0] arg);
        ssru_host_model_inst.send(op, arg, ok);
        check(ok, 1'b1);
        if (!ok) tally_and_finish();
    endtask

    task automatic query(input ssru_op_e op, input logic [7:0] exp);
        do_cmd(op, 8'h00);
        check(rsp_valid, 1'b1);
        check(rsp_data, exp);
    endtask

    task automatic sum_pulse(input logic [2:0] w);
        @(negedge clk);
        {oper, ques, esb} = w;
        @(negedge clk);
        {oper, ques, esb} = 3'b000;
    endtask

    task automatic do_reset(input logic p, input logic [7:0] s, e);
        bit seen;
        seen = 1'b0;
        @(negedge clk);
        rst_n = 1'b0;
        nv = '{psc: p, service_request_mask: s, ese: e};
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) begin
            @(negedge clk);
            if (st_clr === 1'b1 && dev_rst === 1'b1) seen = 1'b1;
        end
        check(seen, 1'b1);
    endtask

    task automatic t_power_on();
        query(OP_SRE_RD, 8'h00);
        query(OP_ESE_RD, 8'h00);
        query(OP_PSC_RD, 8'h01);
        mav = 1'b1;
        do_reset(1'b0, 8'h10, 8'hA5);
        query(OP_SRE_RD, 8'h10);
        check(ese_mask, 8'hA5);
        check(srq, 1'b1);
        do_cmd(OP_ESE_WR, 8'h5A);
        check(nv_wr, 1'b1);
        check(nv_data, {1'b0, 8'h10, 8'h5A});
        query(OP_PSC_RD, 8'h00);
        mav = 1'b0;
        do_reset(1'b1, 8'h10, 8'hA5);
        check(ese_mask, 8'h00);
    endtask

    task automatic t_status_bits();
        sum_pulse(3'b100);
        query(OP_STB_RD, 8'h80);
        do_cmd(OP_EVT_RD, 8'h07);
        sum_pulse(3'b010);
        query(OP_STB_RD, 8'h88);
        mav = 1'b1;
        sum_pulse(3'b001);
        query(OP_STB_RD, 8'hB8);
        query(OP_STB_RD, 8'hB8);
        check(srq, 1'b0);
        do_cmd(OP_EVT_RD, SSRU_EVT_OPER);
        query(OP_STB_RD, 8'h38);
        do_cmd(OP_EVT_RD, SSRU_EVT_QUES);
        query(OP_STB_RD, 8'h30);
        mav = 1'b0;
        do_cmd(OP_EVT_RD, SSRU_EVT_ESR);
        query(OP_STB_RD, 8'h00);
    endtask

    task automatic t_request();
        mav = 1'b1;
        do_cmd(OP_SRE_WR, 8'h10);
        check(nv_wr, 1'b0);
        query(OP_SRE_RD, 8'h10);
        check(srq, 1'b1);
        query(OP_STB_RD, 8'h50);
        ssru_host_model_inst.poll();
        check(spoll_valid, 1'b1);
        check(spoll_data, 8'h50);
        check(srq, 1'b0);
        query(OP_STB_RD, 8'h50);
        ssru_host_model_inst.poll();
        check(spoll_data, 8'h10);
        mav = 1'b0;
        repeat (2) @(negedge clk);
        mav = 1'b1;
        repeat (3) @(negedge clk);
        check(srq, 1'b1);
        do_cmd(OP_SRE_WR, 8'h00);
        @(negedge clk);
        check(srq, 1'b0);
        query(OP_STB_RD, 8'h10);
        mav = 1'b0;
    endtask

    task automatic t_clear();
        do_cmd(OP_SRE_WR, 8'hFF);
        do_cmd(OP_ESE_WR, 8'h3C);
        sum_pulse(3'b111);
        @(negedge clk);
        dcl = 1'b1;
        @(negedge clk);
        dcl = 1'b0;
        query(OP_STB_RD, 8'h00);
        query(OP_SRE_RD, 8'hFF);
        query(OP_ESE_RD, 8'h3C);
        sum_pulse(3'b111);
        do_cmd(OP_RST, 8'h00);
        query(OP_STB_RD, 8'h00);
        check(ese_mask, 8'h3C);
        sum_pulse(3'b111);
        do_cmd(OP_CLS, 8'h00);
        query(OP_STB_RD, 8'h00);
        do_cmd(OP_SRE_WR, 8'h00);
    endtask

    task automatic t_trigger();
        trig_src = 4'hA;
        @(negedge clk);
        get = 1'b1;
        @(negedge clk);
        get = 1'b0;
        check(trig, 4'hA);
        trig_src = 4'h5;
        do_cmd(OP_TRG, 8'h00);
        check(trig, 4'h5);
    endtask

    task automatic t_wait();
        do_cmd(OP_OVL, 8'h00);
        check(ovl_start, 1'b1);
        do_cmd(OP_WAI, 8'h00);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(n >= 6 && n <= 10, 1'b1);
        if (cmd_ready !== 1'b1) tally_and_finish();
        check(ovl_busy, 1'b0);
        do_cmd(OP_SEQ, 8'h00);
        check(seq_start, 1'b1);
        do_cmd(OP_OVL, 8'h00);
        do_cmd(OP_WAI, 8'h00);
        do_cmd(OP_SEQ, 8'h00);
        check(seq_start, 1'b1);
        check(ovl_busy, 1'b1);
        repeat (12) @(negedge clk);
    endtask

    task automatic t_save_recall();
        for (int i = 0; i < SSRU_SLOTS; i++) begin
            state = 32'hC0DE0000 | 32'(i);
            do_cmd(OP_SAV, 8'(i));
        end
        state = 32'hFFFFFFFF;
        for (int i = SSRU_SLOTS - 1; i >= 0; i--) begin
            do_cmd(OP_RCL, 8'(i));
            check(rcl_valid, 1'b1);
            check(rcl_data, 32'hC0DE0000 | 32'(i));
        end
    endtask

    initial begin
        do_reset(1'b1, 8'h10, 8'hA5);
        t_power_on();
        t_status_bits();
        t_request();
        t_clear();
        t_trigger();
        t_wait();
        t_save_recall();
        tally_and_finish();
    end
endmodule
